//--- logic/kbd_disp_pkg.sv
// Purpose: shared constants for the keyboard/display scan controller
// Assumes: one core clock clk_sys at 10 MHz
// Notes:   command codes live in bits 7:5 of a command byte
package kbd_disp_pkg;
  // -------------------------------------------------------------------
  // command codes
  // -------------------------------------------------------------------
  localparam logic [2:0] CMD_MODE     = 3'h0;
  localparam logic [2:0] CMD_PRESCALE = 3'h1;
  localparam logic [2:0] CMD_FIFO_RD  = 3'h2;
  localparam logic [2:0] CMD_DISP_RD  = 3'h3;
  localparam logic [2:0] CMD_DISP_WR  = 3'h4;
  localparam logic [2:0] CMD_WR_MODE  = 3'h5;
  localparam logic [2:0] CMD_CLEAR    = 3'h6;
  localparam logic [2:0] CMD_ACK      = 3'h7;
  // -------------------------------------------------------------------
  // reset values and counts
  // -------------------------------------------------------------------
  localparam logic [4:0] PRESCALE_RST = 5'h1f;
  localparam logic [4:0] PRESCALE_MIN = 5'h02;
  localparam logic [5:0] SCAN_DIV_MAX = 6'h3f;
  localparam logic [4:0] MODE_RST     = 5'h00;
  localparam int         FIFO_DEPTH   = 8;
  localparam int         FIFO_WIDTH   = 8;
  localparam int         BLANK_NS     = 500;
  localparam int         CLK_NS       = 100;
  localparam logic [3:0] BLANK_CYC    = 4'((BLANK_NS + CLK_NS - 1) / CLK_NS);
  // -------------------------------------------------------------------
  // input modes (mode bits 1:0)
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    IN_KEY_LOCK = 2'b00,
    IN_KEY_ROLL = 2'b01,
    IN_SENSOR   = 2'b10,
    IN_STROBED  = 2'b11
  } in_mode_t;
  localparam logic [7:0] FILL_SPACE = 8'h20;
endpackage : kbd_disp_pkg

//--- logic/sync_fifo.sv
// Purpose: holds no logic; the queue module sits in kbd_disp_ctrl.sv
// Assumes: nothing
// Notes:   one design file carries all the logic of the block

//--- logic/kbd_disp_ctrl.sv
// Purpose: scanned keyboard, sensor and strobed input with display scan
// Assumes: host strobes and pins are synchronous to clk_sys
// Notes:   host strobes are edge-detected in the core clock domain
`timescale 1ns/100ps
// Overview of operation
// (RULE_01) output enable low only on selected read
// (RULE_02) write rising edge captures data and select
// (RULE_03) captured write executes one core cycle later
// (RULE_04) read falling edge picks status or data
// (RULE_05) eight command registers, some trigger actions
// (RULE_06) prescaler divides scan reference by 2..31
// (RULE_07) scan divider by 64 gives scan enable
// (RULE_08) four-bit scan counter, encoded or decoded
// (RULE_09) decoded scan shows only four characters
// (RULE_10) blank display around scan counter changes
// (RULE_11) address commands load access counter, autoincrement; FIFO read stores finc_q but never steps fra_q
// (RULE_12) nibble writes can be inhibited separately
// (RULE_13) display address cycles 16, 8 or 4
// (RULE_14) clear fills ones, zeros or space
// (RULE_15) display memory as two 16x4 halves
// (RULE_16) invert returns, register per scan state
// (RULE_17) keyboard debounce over two scan cycles
// (RULE_18) sensor mode writes returns each scan count; code skips the write while the sensor interrupt sirq_q is pending
// (RULE_19) strobed mode pushes returns on strobe rise
// (RULE_20) eight-byte queue or sensor image RAM
// (RULE_21) full, empty, count and error in status
// (RULE_22) queue interrupt drops on each read
// (RULE_23) sensor interrupt set on change, acked
// (RULE_24) reset gives 16 left, encoded lockout, 31
// (RULE_25) scan enable is a single-cycle pulse
module kbd_disp_ctrl
  import kbd_disp_pkg::*;
(
  input  wire logic       clk_sys,              // core clock
  input  wire logic       rstn,                 // sync reset, low
  input  wire logic       scan_ref,             // external scan reference
  input  wire logic [7:0] host_write_bus,       // host write data
  input  wire logic       command_data_select,  // high command, low data
  input  wire logic       cs_n,                 // chip select, low
  input  wire logic       rd_n,                 // read strobe, low
  input  wire logic       wr_n,                 // write strobe, low
  input  wire logic [7:0] return_lines,         // key returns, low active
  input  wire logic       shift_input,          // shift key level
  input  wire logic       control_strobe_input, // control key or strobe
  output logic      [7:0] host_read_bus,        // host read data
  output logic            out_en_n,             // read buffer enable, low
  output logic      [3:0] scan_lines,           // scan outputs
  output logic      [3:0] disp_a,               // display high nibble
  output logic      [3:0] disp_b,               // display low nibble
  output logic            display_blank_n,      // blanking, low
  output logic            irq                   // service request
);
  // -------------------------------------------------------------------
  // host strobe edges and captured write
  // -------------------------------------------------------------------
  logic       wr_n_q, rd_n_q, ref_q, ctl_q;
  logic [7:0] wdat_q, wdat_d;
  logic       wsel_q, wsel_d, wgo_q, wgo_d, rsel_q, rsel_d;
  logic       wr_rise, rd_fall, rd_rise, ref_rise, ctl_rise;
  assign wr_rise  = !wr_n_q && wr_n && !cs_n;
  assign rd_fall  = rd_n_q && !rd_n && !cs_n;
  assign rd_rise  = !rd_n_q && rd_n;
  assign ref_rise = !ref_q && scan_ref;
  assign ctl_rise = !ctl_q && control_strobe_input;
  always_comb begin
    wdat_d = wdat_q;
    wsel_d = wsel_q;
    wgo_d  = wr_rise;                                // see RULE_03
    rsel_d = rsel_q;
    if (wr_rise) begin                               // see RULE_02
      wdat_d = host_write_bus;
      wsel_d = command_data_select;
    end
    if (rd_fall) rsel_d = command_data_select;       // see RULE_04
  end
  // -------------------------------------------------------------------
  // control registers, prescaler, scan generator
  // -------------------------------------------------------------------
  logic [4:0] mode_q, mode_d, pre_q, pre_d, pcnt_q, pcnt_d;
  logic [5:0] sdiv_q, sdiv_d;
  logic       stick_q, stick_d, sen_q, sen_d;
  logic [3:0] scnt_q, scnt_d, blk_q, blk_d;
  logic [2:0] fra_q, fra_d;
  logic       rdsrc_q, rdsrc_d, ai_q, ai_d, finc_q, finc_d;
  logic [1:0] inh_q, inh_d;
  logic       decoded, disp8, right_ent;
  in_mode_t   imode;
  assign decoded   = mode_q[2];
  assign disp8     = mode_q[3];
  assign right_ent = mode_q[4];
  assign imode     = in_mode_t'(mode_q[1:0]);
  logic [3:0] dcnt_q, dcnt_d, rwa_q, rwa_d;
  logic       clr_q, clr_d;
  logic [7:0] fillv_q, fillv_d;
  logic [3:0] hi_q [16];
  logic [3:0] lo_q [16];
  logic [3:0] hi_d [16];
  logic [3:0] lo_d [16];
  logic [7:0] sram_q [8];
  logic [7:0] sram_d [8];
  logic [7:0] rl_q [16];
  logic [7:0] rl_d [16];
  logic [7:0] prv_q [16];
  logic [7:0] prv_d [16];
  logic       sirq_q, sirq_d, err_q, err_d, irqh_q, irqh_d;
  logic       kpush;
  logic [7:0] kword;
  logic       f_ready, f_valid, f_pop;
  logic [7:0] f_data;
  logic [3:0] fcnt_q, fcnt_d;
  logic [7:0] rdat_q, rdat_d;
  logic [3:0] a_d, b_d, sl_d;
  logic       blank_d, oen_d;

  // step the display count modulo the active length
  function automatic logic [3:0] scan_wrap(input logic [3:0] v, input logic dec,
                                           input logic d8);
    logic [3:0] m;
    m = dec ? 4'h3 : (d8 ? 4'h7 : 4'hf);
    return (v + 4'h1) & m;
  endfunction : scan_wrap

  // index of the lowest set bit
  function automatic logic [2:0] low_bit(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) if (v[i]) r = 3'(i);
    return r;
  endfunction : low_bit

  always_comb begin
    mode_d  = mode_q;
    pre_d   = pre_q;
    fra_d   = fra_q;
    rdsrc_d = rdsrc_q;
    ai_d    = ai_q;
    finc_d  = finc_q;
    inh_d   = inh_q;
    fillv_d = fillv_q;
    if (wgo_q && wsel_q) begin                       // see RULE_05
      case (wdat_q[7:5])
        CMD_MODE:     mode_d = wdat_q[4:0];
        CMD_PRESCALE: pre_d = (wdat_q[4:0] < PRESCALE_MIN) ? PRESCALE_MIN : wdat_q[4:0];
        CMD_FIFO_RD: begin
          fra_d   = wdat_q[2:0];
          finc_d  = wdat_q[4];
          rdsrc_d = 1'b0;
        end
        CMD_DISP_RD, CMD_DISP_WR: begin
          ai_d    = wdat_q[4];
          rdsrc_d = 1'b1;
        end
        CMD_WR_MODE:  inh_d = wdat_q[1:0];
        CMD_CLEAR:    fillv_d = wdat_q[1] ? (wdat_q[0] ? 8'hff : FILL_SPACE) : 8'h00;
        default: ;
      endcase
    end
  end

  always_comb begin
    pcnt_d  = pcnt_q;
    sdiv_d  = sdiv_q;
    stick_d = stick_q;
    sen_d   = 1'b0;
    scnt_d  = scnt_q;
    blk_d   = (blk_q != 4'h0) ? blk_q - 4'h1 : 4'h0;
    if (ref_rise) begin                              // see RULE_06
      if (pcnt_q >= pre_q - 5'h1) begin
        pcnt_d = 5'h0;
        sdiv_d = sdiv_q + 6'h1;                      // see RULE_07
        if (sdiv_q == SCAN_DIV_MAX) stick_d = 1'b1;
      end else begin
        pcnt_d = pcnt_q + 5'h1;
      end
    end
    if (stick_q) begin                               // see RULE_25
      stick_d = 1'b0;
      sen_d   = 1'b1;
    end
    if (sen_q) begin
      scnt_d = decoded ? {2'b00, scnt_q[1:0] + 2'h1} : scnt_q + 4'h1; // see RULE_08
      blk_d  = BLANK_CYC;                            // see RULE_10
    end
    if (stick_q) blk_d = BLANK_CYC;
  end
  // -------------------------------------------------------------------
  // display counters, memory and clear
  // -------------------------------------------------------------------
  always_comb begin
    hi_d   = hi_q;
    lo_d   = lo_q;
    rwa_d  = rwa_q;
    clr_d  = clr_q;
    dcnt_d = dcnt_q;
    if (sen_q) dcnt_d = scan_wrap(dcnt_q, decoded, disp8); // see RULE_13 RULE_09
    if (wgo_q && wsel_q) begin
      if (wdat_q[7:5] == CMD_DISP_RD || wdat_q[7:5] == CMD_DISP_WR)
        rwa_d = wdat_q[3:0];                         // see RULE_11
      if (wdat_q[7:5] == CMD_CLEAR && wdat_q[2]) begin
        clr_d = 1'b1;                                // see RULE_14
        rwa_d = 4'h0;
      end
    end
    if (clr_q) begin
      hi_d[rwa_q] = fillv_q[7:4];
      lo_d[rwa_q] = fillv_q[3:0];
      rwa_d = rwa_q + 4'h1;
      if (rwa_q == 4'hf) clr_d = 1'b0;
    end else if (wgo_q && !wsel_q && rdsrc_q) begin
      if (!inh_q[1]) hi_d[rwa_q] = wdat_q[7:4];      // see RULE_12 RULE_15
      if (!inh_q[0]) lo_d[rwa_q] = wdat_q[3:0];
      if (ai_q) rwa_d = rwa_q + 4'h1;
      // right entry shifts the shown window with each write
      if (right_ent) dcnt_d = scan_wrap(dcnt_d, decoded, disp8);
    end else if (rd_rise && !rsel_q && rdsrc_q && ai_q) begin
      rwa_d = rwa_q + 4'h1;
    end
  end
  // -------------------------------------------------------------------
  // return lines, debounce, sensor image
  // -------------------------------------------------------------------
  always_comb begin
    logic [7:0] cur, closed;
    cur    = ~return_lines;                          // see RULE_16
    rl_d   = rl_q;
    prv_d  = prv_q;
    sram_d = sram_q;
    sirq_d = sirq_q;
    kpush  = 1'b0;
    kword  = 8'h00;
    closed = 8'h00;
    if (sen_q && imode != IN_STROBED) begin
      prv_d[scnt_q] = rl_q[scnt_q];
      rl_d[scnt_q]  = cur;
      // pressed in this and the last scan, released in the one before
      closed = cur & rl_q[scnt_q] & ~prv_q[scnt_q]; // see RULE_17
      if (imode != IN_SENSOR && closed != 8'h00) begin
        kpush = 1'b1;
        kword = {control_strobe_input, shift_input, scnt_q[2:0], low_bit(closed)};
      end
      if (imode == IN_SENSOR && !sirq_q && sram_q[scnt_q[2:0]] != cur) begin
        sram_d[scnt_q[2:0]] = cur;                   // see RULE_18 RULE_20
        sirq_d = 1'b1;                               // see RULE_23
      end
    end
    if (imode == IN_STROBED && ctl_rise) begin       // see RULE_19
      kpush = 1'b1;
      kword = cur;
    end
    // set wins over a same-cycle acknowledge
    if (wgo_q && wsel_q && wdat_q[7:5] == CMD_ACK && !(sirq_d && !sirq_q)) sirq_d = 1'b0;
  end
  // -------------------------------------------------------------------
  // queue, status, read data, outputs
  // -------------------------------------------------------------------
  // display reads must not pop the queue or flag underflow
  assign f_pop = rd_fall && !command_data_select && !rdsrc_q && imode != IN_SENSOR;
  sync_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (kpush),
    .in_ready  (f_ready),
    .in_data   (kword),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );
  always_comb begin
    fcnt_d = fcnt_q;
    err_d  = err_q;
    irqh_d = 1'b1;
    if (kpush && f_ready && !(f_pop && f_valid)) fcnt_d = fcnt_q + 4'h1; // see RULE_21
    if (f_pop && f_valid && !(kpush && f_ready)) fcnt_d = fcnt_q - 4'h1;
    if (wgo_q && wsel_q && wdat_q[7:5] == CMD_ACK) err_d = 1'b0;
    if ((kpush && !f_ready) || (f_pop && !f_valid)) err_d = 1'b1;
    if (f_pop) irqh_d = 1'b0;                        // see RULE_22
    rdat_d = rdat_q;
    if (rd_fall) begin
      if (command_data_select)
        rdat_d = {sirq_q, err_q, 1'b0, 1'b0, fcnt_q == 4'h8, fcnt_q[2:0]};
      else if (rdsrc_q)
        rdat_d = {hi_q[rwa_q], lo_q[rwa_q]};
      else if (imode == IN_SENSOR)
        rdat_d = sram_q[fra_q];
      else
        rdat_d = f_data;
    end
    oen_d   = rd_n | cs_n;                           // see RULE_01
    sl_d    = decoded ? (4'h1 << scnt_q[1:0]) : scnt_q;
    a_d     = hi_q[dcnt_q];
    b_d     = lo_q[dcnt_q];
    blank_d = (blk_q == 4'h0) && !stick_q;           // see RULE_10
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_n_q <= 1'b1; rd_n_q <= 1'b1; ref_q <= 1'b0; ctl_q <= 1'b0;
      wdat_q <= 8'h00; wsel_q <= 1'b0; wgo_q <= 1'b0; rsel_q <= 1'b0;
      mode_q <= MODE_RST; pre_q <= PRESCALE_RST;     // see RULE_24
      pcnt_q <= 5'h0; sdiv_q <= 6'h0; stick_q <= 1'b0; sen_q <= 1'b0;
      scnt_q <= 4'h0; blk_q <= 4'h0; fra_q <= 3'h0; rdsrc_q <= 1'b1;
      ai_q <= 1'b0; finc_q <= 1'b0; inh_q <= 2'b00; fillv_q <= 8'h00;
      dcnt_q <= 4'h0; rwa_q <= 4'h0; clr_q <= 1'b0;
      sirq_q <= 1'b0; err_q <= 1'b0; irqh_q <= 1'b1; fcnt_q <= 4'h0;
      rdat_q <= 8'h00; host_read_bus <= 8'h00; out_en_n <= 1'b1;
      scan_lines <= 4'h0; disp_a <= 4'h0; disp_b <= 4'h0;
      display_blank_n <= 1'b0; irq <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        hi_q[i] <= 4'h0; lo_q[i] <= 4'h0; rl_q[i] <= 8'h00; prv_q[i] <= 8'h00;
      end
      for (int i = 0; i < 8; i++) sram_q[i] <= 8'h00;
    end else begin
      wr_n_q <= wr_n; rd_n_q <= rd_n; ref_q <= scan_ref; ctl_q <= control_strobe_input;
      wdat_q <= wdat_d; wsel_q <= wsel_d; wgo_q <= wgo_d; rsel_q <= rsel_d;
      mode_q <= mode_d; pre_q <= pre_d;
      pcnt_q <= pcnt_d; sdiv_q <= sdiv_d; stick_q <= stick_d; sen_q <= sen_d;
      scnt_q <= scnt_d; blk_q <= blk_d; fra_q <= fra_d; rdsrc_q <= rdsrc_d;
      ai_q <= ai_d; finc_q <= finc_d; inh_q <= inh_d; fillv_q <= fillv_d;
      dcnt_q <= dcnt_d; rwa_q <= rwa_d; clr_q <= clr_d;
      hi_q <= hi_d; lo_q <= lo_d; rl_q <= rl_d; prv_q <= prv_d; sram_q <= sram_d;
      sirq_q <= sirq_d; err_q <= err_d; irqh_q <= irqh_d; fcnt_q <= fcnt_d;
      rdat_q <= rdat_d; host_read_bus <= rdat_d; out_en_n <= oen_d;
      scan_lines <= sl_d; disp_a <= a_d; disp_b <= b_d;
      display_blank_n <= blank_d;
      irq <= (imode == IN_SENSOR) ? sirq_d : (f_valid && irqh_d && !f_pop);
    end
  end
endmodule : kbd_disp_ctrl

// -------------------------------------------------------------------
// queue in flip-flops; push to full and pop of empty are ignored
// -------------------------------------------------------------------
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,  // core clock
  input  wire logic             rstn,     // sync reset, low
  input  wire logic             in_valid, // push request
  output logic                  in_ready, // room left
  input  wire logic [WIDTH-1:0] in_data,  // push data
  output logic                  out_valid,// data waiting
  input  wire logic             out_ready,// pop request
  output logic      [WIDTH-1:0] out_data  // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule : sync_fifo

//--- test/kbd_disp_chk.sv
// Purpose: port checks for kbd_disp_ctrl
// Assumes: host strobes idle high during reset
// Notes:   scan checks pause for 8 cycles after any host write
`timescale 1ns/100ps
module kbd_disp_chk (
  input wire logic       clk_sys,         // core clock
  input wire logic       rstn,            // sync reset, low
  input wire logic       cs_n,            // chip select
  input wire logic       rd_n,            // read strobe
  input wire logic       wr_n,            // write strobe
  input wire logic [7:0] host_read_bus,   // read data
  input wire logic       out_en_n,        // read enable
  input wire logic [3:0] scan_lines,      // scan outputs
  input wire logic       display_blank_n, // blanking
  input wire logic       irq              // service request
);
  // ---------------------------------------------------------------
  // history of strobes and scan value
  // ---------------------------------------------------------------
  logic [7:0] wr_hist_q;
  logic [7:0] wr_hist_d;
  logic [7:0] rd_hist_q;
  logic [7:0] rd_hist_d;
  logic [3:0] scan_last_q;
  logic [3:0] scan_last_d;
  logic       quiet;
  always_comb begin
    wr_hist_d = {wr_hist_q[6:0], wr_n};
    rd_hist_d = {rd_hist_q[6:0], rd_n};
    scan_last_d = scan_lines;
  end
  always_ff @(posedge clk_sys) begin
    wr_hist_q <= rstn ? wr_hist_d : 8'hff;
    rd_hist_q <= rstn ? rd_hist_d : 8'hff;
    scan_last_q <= rstn ? scan_last_d : 4'h0;
  end
  // mode writes may reshape scan lines without a step
  assign quiet = &wr_hist_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence blank_tail;
    !display_blank_n [*6] ##1 display_blank_n;
  endsequence
  sequence scan_step;
    $changed(scan_lines) && quiet;
  endsequence
  AST_OE: assert property (out_en_n == $past(rd_n | cs_n))
    else $error("output enable does not follow read and select");
  AST_RD_CHG: assert property ($changed(host_read_bus) |->
    $past(!rd_n && !cs_n) && $past(rd_n, 2))
    else $error("read data changed without a read");
  AST_OE_HOLD: assert property (!out_en_n && !$past(out_en_n) && !$past(out_en_n, 2)
    |-> $stable(host_read_bus))
    else $error("read data moved during a read");
  AST_BLANK_LEN: assert property ($fell(display_blank_n) |=> blank_tail)
    else $error("blank pulse length wrong");
  AST_BLANK_CAUSE: assert property ($fell(display_blank_n) |->
    ##[0:5] $changed(scan_lines))
    else $error("blank without a scan step");
  AST_SCAN_BLANK: assert property (scan_step |->
    (!$past(display_blank_n) || !display_blank_n) or (##1 !display_blank_n))
    else $error("scan step while display lit");
  AST_SCAN_SUCC: assert property (scan_step |->
    scan_lines == scan_last_q + 4'h1 || scan_lines == {scan_last_q[2:0], scan_last_q[3]})
    else $error("scan lines skipped a state");
  AST_IRQ_FALL: assert property ($fell(irq) |-> !quiet || !(&rd_hist_q))
    else $error("service request dropped without host access");
endmodule : kbd_disp_chk

bind kbd_disp_ctrl kbd_disp_chk chk (
  .clk_sys, .rstn, .cs_n, .rd_n, .wr_n, .host_read_bus, .out_en_n,
  .scan_lines, .display_blank_n, .irq
);

//--- test/host_bus_model.sv
// Purpose: host processor on the strobed byte bus
// Assumes: one access at a time, strobes move after rising edges
// Notes:   released write bus shows the inverse of the last byte
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic       clk_sys,             // core clock
  input  wire logic [7:0] host_read_bus,       // read data
  output logic      [7:0] host_write_bus,      // write data
  output logic            command_data_select, // high command
  output logic            cs_n,                // chip select, low
  output logic            rd_n,                // read strobe, low
  output logic            wr_n                 // write strobe, low
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial begin
    host_write_bus = 8'h00;
    command_data_select = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    host_write_bus <= d;
    command_data_select <= sel;
    @(posedge clk_sys);
    wr_n <= 1'b1;
    @(posedge clk_sys);
    cs_n <= 1'b1;
    host_write_bus <= ~d;
    command_data_select <= ~sel;
    repeat (3) @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic sel, output logic [7:0] d);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    command_data_select <= sel;
    repeat (3) @(posedge clk_sys);
    d = host_read_bus;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : rd
endmodule : host_bus_model

//--- test/tb_top.sv
// Purpose: self-checking bench for kbd_disp_ctrl
// Assumes: scan reference toggles every core cycle
// Notes:   keyboard debounce is not exercised by this bench
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top;
  import kbd_disp_pkg::*;
  logic       clk_sys;
  logic       rstn;
  logic       scan_ref = 1'b0;
  logic [7:0] return_lines;
  logic       shift_input;
  logic       control_strobe_input;
  wire logic [7:0] host_write_bus;
  wire logic       command_data_select;
  wire logic       cs_n;
  wire logic       rd_n;
  wire logic       wr_n;
  wire logic [7:0] host_read_bus;
  wire logic       out_en_n;
  wire logic [3:0] scan_lines;
  wire logic [3:0] disp_a;
  wire logic [3:0] disp_b;
  wire logic       display_blank_n;
  wire logic       irq;
  int         errors = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         n;
  int         i;
  logic [7:0] d;
  logic [2:0] clr_code [3] = '{3'h7, 3'h6, 3'h4};
  logic [7:0] clr_fill [3] = '{8'hff, 8'h20, 8'h00};
  kbd_disp_ctrl uut (
    .clk_sys, .rstn, .scan_ref, .host_write_bus, .command_data_select,
    .cs_n, .rd_n, .wr_n, .return_lines, .shift_input, .control_strobe_input,
    .host_read_bus, .out_en_n, .scan_lines, .disp_a, .disp_b,
    .display_blank_n, .irq
  );
  host_bus_model host (
    .clk_sys, .host_read_bus, .host_write_bus, .command_data_select,
    .cs_n, .rd_n, .wr_n
  );
  // ---------------------------------------------------------------
  // clocks, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    scan_ref <= ~scan_ref;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // bounded wait, cycles until the scan lines move
  task automatic wait_step(output int k);
    logic [3:0] s;
    s = scan_lines;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (scan_lines === s && k < 5000);
  endtask : wait_step
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    return_lines = 8'hff;
    shift_input = 1'b0;
    control_strobe_input = 1'b0;
    repeat (8) @(posedge clk_sys);
    `CHK("blank_rst", 1'b0, display_blank_n)
    `CHK("oe_rst", 1'b1, out_en_n)
    rstn <= 1'b1;
    host.rd(1'b1, d);
    `CHK("status_rst", 8'h00, d)
    wait_step(n);
    wait_step(n);
    `CHK("step_rst", 64 * 31 * 2, n)
    host.wr(1'b1, {CMD_PRESCALE, 5'h02});
    host.wr(1'b1, {CMD_DISP_WR, 5'h10});
    host.wr(1'b0, 8'ha5);
    host.wr(1'b0, 8'h3c);
    host.wr(1'b1, {CMD_DISP_RD, 5'h10});
    host.rd(1'b0, d);
    `CHK("disp0", 8'ha5, d)
    host.rd(1'b0, d);
    `CHK("disp1", 8'h3c, d)
    n = 0;
    while (!(scan_lines === 4'h0 && display_blank_n === 1'b1) && n < 5000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK("disp_out", 8'ha5, {disp_a, disp_b})
    for (i = 0; i < 2; i++) begin
      host.wr(1'b1, {CMD_WR_MODE, 5'(2 - i)});
      host.wr(1'b1, {CMD_DISP_WR, 5'(i)});
      host.wr(1'b0, {8{i == 0}});
      host.wr(1'b1, {CMD_DISP_RD, 5'(i)});
      host.rd(1'b0, d);
      `CHK("nibble", (i == 0) ? 8'haf : 8'h0c, d)
    end
    host.wr(1'b1, {CMD_WR_MODE, 5'h00});
    for (i = 0; i < 3; i++) begin
      host.wr(1'b1, {CMD_CLEAR, 2'b00, clr_code[i]});
      repeat (20) @(posedge clk_sys);
      host.wr(1'b1, {CMD_DISP_RD, 5'h05});
      host.rd(1'b0, d);
      `CHK("clear", clr_fill[i], d)
    end
    host.wr(1'b1, {CMD_MODE, 5'h03});
    host.wr(1'b1, {CMD_FIFO_RD, 5'h00});
    for (i = 0; i < 9; i++) begin
      if (i == 8) begin
        host.rd(1'b1, d);
        `CHK("full", 8'h08, d)
        `CHK("irq_set", 1'b1, irq)
      end
      @(posedge clk_sys);
      return_lines <= ~8'(i * 17 + 1);
      @(posedge clk_sys);
      control_strobe_input <= 1'b1;
      repeat (3) @(posedge clk_sys);
      control_strobe_input <= 1'b0;
      return_lines <= 8'hff;
      repeat (2) @(posedge clk_sys);
    end
    host.rd(1'b1, d);
    `CHK("overflow", 8'h48, d)
    for (i = 0; i < 8; i++) begin
      host.rd(1'b0, d);
      `CHK("queue", 8'(i * 17 + 1), d)
    end
    `CHK("irq_clr", 1'b0, irq)
    host.wr(1'b1, {CMD_ACK, 5'h00});
    host.rd(1'b1, d);
    `CHK("ack", 8'h00, d)
    host.rd(1'b0, d);
    host.rd(1'b1, d);
    `CHK("underflow", 8'h40, d)
    host.wr(1'b1, {CMD_ACK, 5'h00});
    host.wr(1'b1, {CMD_MODE, 5'h04});
    wait_step(n);
    wait_step(n);
    `CHK("step_div2", 64 * 2 * 2, n)
    `CHK("decoded", 1'b1, $onehot(scan_lines))
    host.wr(1'b1, {CMD_MODE, 5'h02});
    return_lines <= 8'ha5;
    wait_step(n);
    `CHK("sensor_irq", 1'b1, irq)
    host.rd(1'b1, d);
    `CHK("sensor_stat", 8'h80, d)
    host.wr(1'b1, {CMD_ACK, 5'h00});
    `CHK("sensor_ack", 1'b0, irq)
    wait_step(n);
    host.wr(1'b1, {CMD_FIFO_RD, 2'b00, 3'(scan_lines - 4'h1)});
    host.rd(1'b0, d);
    `CHK("sensor_ram", 8'h5a, d)
    complete_run();
  end
endmodule : tb_top
